/* ssd_pkg.sv */
// Constants for the servo serial command decoder: command codes, data
// numbers, answer codes, field lengths and input device bit positions.
// Assumes framing, checksum and character conversion happen upstream.
`default_nettype none
package ssd_pkg;
   localparam logic [7:0]  CMD_DREG_READ   = 8'h6e;
   localparam logic [7:0]  CMD_REG_COUNT   = 8'h6f;
   localparam logic [7:0]  CMD_OTHERS      = 8'h00;
   localparam logic [7:0]  CMD_POS_VER     = 8'h02;
   localparam logic [7:0]  CMD_STAT_CLR    = 8'h81;
   localparam logic [7:0]  CMD_GROUP_SEL   = 8'h85;
   localparam logic [7:0]  CMD_PARAM_WR    = 8'h94;
   localparam logic [7:0]  CMD_EXT_IN      = 8'h92;
   localparam logic [7:0]  CMD_ALARM       = 8'h82;
   localparam logic [7:0]  CMD_PROHIBIT    = 8'h90;

   localparam logic [7:0]  DNO_00          = 8'h00;
   localparam logic [7:0]  DNO_01          = 8'h01;
   localparam logic [7:0]  DNO_DREG_LAST   = 8'h04;
   localparam logic [7:0]  DNO_TEST_MODE   = 8'h12;
   localparam logic [7:0]  DNO_STORE_TYPE  = 8'h1d;
   localparam logic [7:0]  DNO_CTRL_MODE   = 8'h1e;
   localparam logic [7:0]  DNO_POS_PULSE   = 8'h90;
   localparam logic [7:0]  DNO_POS_CMD     = 8'h91;
   localparam logic [7:0]  DNO_VERSION     = 8'h70;
   localparam logic [7:0]  DNO_EXT_FIRST   = 8'h60;
   localparam logic [7:0]  DNO_EXT_LAST    = 8'h62;
   localparam logic [7:0]  DNO_HIST_CLR    = 8'h20;
   localparam logic [7:0]  DNO_IN_OFF      = 8'h00;
   localparam logic [7:0]  DNO_OUT_OFF     = 8'h03;
   localparam logic [7:0]  DNO_IN_ON       = 8'h10;
   localparam logic [7:0]  DNO_OUT_ON      = 8'h13;

   localparam logic [15:0] CLEAR_KEY       = 16'h1ea5;
   localparam logic [15:0] MODE_POINT      = 16'h0006;
   localparam logic [15:0] MODE_PROGRAM    = 16'h0007;
   localparam logic [3:0]  GROUP_LAST_STD  = 4'h5;
   localparam logic [3:0]  GROUP_POSITION  = 4'hc;
   localparam logic [3:0]  GROUP_RESET     = 4'h0;

   localparam logic [4:0]  LEN_NONE        = 5'h00;
   localparam logic [4:0]  LEN_4           = 5'h04;
   localparam logic [4:0]  LEN_8           = 5'h08;
   localparam logic [4:0]  LEN_16          = 5'h10;

   localparam int          DIN_W           = 16;
   localparam int          DOUT_W          = 16;
   localparam int          FORCED_STOP_BIT = 0;
   localparam int          FWD_STROKE_BIT  = 1;
   localparam int          REV_STROKE_BIT  = 2;
   localparam logic [15:0] DIN_EXEMPT      = 16'h0007;
   // Arbitrary value, stands in for a real version string
   localparam logic [63:0] FW_VERSION_DEF  = 64'h0000_0000_0000_0001;
endpackage
`default_nettype wire

/* ssd_io_gate.sv */
// Input and output device gating under prohibition.
// Assumes prohibit levels come from the decoder in the same clock domain.
`default_nettype none
module ssd_io_gate (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        in_proh,
   input  wire logic        out_proh,
   input  wire logic [15:0] din_raw,
   input  wire logic [15:0] dout_req,
   output logic      [15:0] din_eff,
   output logic      [15:0] dout_eff
);
   typedef struct packed {
      logic [15:0] din;
      logic [15:0] dout;
   } ssd_gate_type;

   ssd_gate_type g_r;
   ssd_gate_type g_nxt;

   always_comb begin
      // Stop and stroke-end inputs stay live so a prohibited link cannot mask safety
      g_nxt.din  = in_proh ? (din_raw & ssd_pkg::DIN_EXEMPT) : din_raw;
      g_nxt.dout = out_proh ? 16'h0000 : dout_req;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         g_r <= '0;
      end else begin
         g_r <= g_nxt;
      end
   end

   assign din_eff  = g_r.din;
   assign dout_eff = g_r.dout;
endmodule
`default_nettype wire

/* ssd_decoder.sv */
// Serial command decoder: executes one decoded read or write per request.
// Assumes requests arrive already parsed into command, data number and
// hex data field, synchronous to CLK_SYS.
`default_nettype none
module ssd_decoder #(
   parameter logic [63:0] FW_VERSION = ssd_pkg::FW_VERSION_DEF
) (
   input  wire logic         CLK_SYS,
   input  wire logic         NRST,
   input  wire logic         CMD_VALID,
   output logic              CMD_READY,
   input  wire logic         CMD_WRITE,
   input  wire logic [7:0]   CMD_CODE,
   input  wire logic [7:0]   CMD_DNO,
   input  wire logic [47:0]  CMD_DATA,
   input  wire logic         PROGRAM_CONTROL,
   input  wire logic [127:0] DATA_GENERAL_REGISTER,
   input  wire logic [31:0]  INT_REG_COUNT,
   input  wire logic [31:0]  DATA_REG_COUNT,
   input  wire logic [15:0]  TEST_MODE_CODE,
   input  wire logic [15:0]  STORE_TYPE_CODE,
   input  wire logic [31:0]  ABS_POS_PULSE,
   input  wire logic [31:0]  ABS_POS_CMD,
   input  wire logic [15:0]  DIN_RAW,
   input  wire logic [15:0]  DOUT_REQ,
   output logic              RSP_VALID,
   output logic              RSP_ERR,
   output logic      [63:0]  RSP_DATA,
   output logic      [4:0]   RSP_LEN,
   output logic              PARAM_WR,
   output logic      [3:0]   PARAM_GROUP,
   output logic      [7:0]   PARAM_INDEX,
   output logic      [47:0]  PARAM_VALUE,
   output logic              EXT_IN_WR,
   output logic      [95:0]  EXT_IN_DATA,
   output logic              STATUS_CLR,
   output logic              ALARM_CLR,
   output logic              ALARM_HIST_CLR,
   output logic              IN_PROHIBIT,
   output logic              OUT_PROHIBIT,
   output logic      [15:0]  DIN_EFF,
   output logic      [15:0]  DOUT_EFF
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RESP = 2'b01
   } ssd_state_type;

   typedef struct packed {
      ssd_state_type st;
      logic          rsp_valid;
      logic          rsp_err;
      logic [63:0]   rd_data;
      logic [4:0]    rd_len;
      logic          param_wr;
      logic [3:0]    group;
      logic [7:0]    index;
      logic [47:0]   value;
      logic          ext_wr;
      logic [95:0]   ext_in;
      logic          stat_clr;
      logic          alm_clr;
      logic          hist_clr;
      logic          in_proh;
      logic          out_proh;
   } ssd_regs_type;

   ssd_regs_type r_r;
   ssd_regs_type r_nxt;

   function automatic logic key_ok(input logic [47:0] d);
      key_ok = (d[15:0] == ssd_pkg::CLEAR_KEY);
   endfunction

   function automatic logic group_ok(input logic [47:0] d);
      group_ok = (d[47:4] == 44'h0) &&
                 ((d[3:0] <= ssd_pkg::GROUP_LAST_STD) || (d[3:0] == ssd_pkg::GROUP_POSITION));
   endfunction

   logic        take;
   logic [1:0]  dreg_sel;
   logic [1:0]  ext_sel;

   assign take     = CMD_VALID && (r_r.st == ST_IDLE);
   assign dreg_sel = 2'(CMD_DNO - ssd_pkg::DNO_01);
   assign ext_sel  = 2'(CMD_DNO - ssd_pkg::DNO_EXT_FIRST);

   always_comb begin
      r_nxt          = r_r;
      r_nxt.param_wr = 1'b0;
      r_nxt.ext_wr   = 1'b0;
      r_nxt.stat_clr = 1'b0;
      r_nxt.alm_clr  = 1'b0;
      r_nxt.hist_clr = 1'b0;
      r_nxt.rsp_valid = 1'b0;
      case (r_r.st)
         ST_IDLE: begin
            if (take) begin
               r_nxt.st        = ST_RESP;
               r_nxt.rsp_valid = 1'b1;
               // Anything not matched below answers with an error and stores nothing
               r_nxt.rsp_err   = 1'b1;
               r_nxt.rd_data   = 64'h0;
               r_nxt.rd_len    = ssd_pkg::LEN_NONE;
               if (!CMD_WRITE) begin
                  case (CMD_CODE)
                     ssd_pkg::CMD_DREG_READ: begin
                        if (PROGRAM_CONTROL && CMD_DNO >= ssd_pkg::DNO_01 &&
                            CMD_DNO <= ssd_pkg::DNO_DREG_LAST) begin
                           r_nxt.rd_data = {32'h0, DATA_GENERAL_REGISTER[dreg_sel*32 +: 32]};
                           r_nxt.rd_len  = ssd_pkg::LEN_8;
                           r_nxt.rsp_err = 1'b0;
                        end
                     end
                     ssd_pkg::CMD_REG_COUNT: begin
                        if (PROGRAM_CONTROL && CMD_DNO == ssd_pkg::DNO_00) begin
                           r_nxt.rd_data = {32'h0, INT_REG_COUNT};
                           r_nxt.rd_len  = ssd_pkg::LEN_8;
                           r_nxt.rsp_err = 1'b0;
                        end else if (PROGRAM_CONTROL && CMD_DNO == ssd_pkg::DNO_01) begin
                           r_nxt.rd_data = {32'h0, DATA_REG_COUNT};
                           r_nxt.rd_len  = ssd_pkg::LEN_8;
                           r_nxt.rsp_err = 1'b0;
                        end
                     end
                     ssd_pkg::CMD_OTHERS: begin
                        r_nxt.rd_len  = ssd_pkg::LEN_4;
                        r_nxt.rsp_err = 1'b0;
                        case (CMD_DNO)
                           ssd_pkg::DNO_TEST_MODE:  r_nxt.rd_data = {48'h0, TEST_MODE_CODE};
                           ssd_pkg::DNO_STORE_TYPE: r_nxt.rd_data = {48'h0, STORE_TYPE_CODE};
                           ssd_pkg::DNO_CTRL_MODE: begin
                              r_nxt.rd_data = {48'h0, PROGRAM_CONTROL ? ssd_pkg::MODE_PROGRAM
                                                                     : ssd_pkg::MODE_POINT};
                           end
                           default: begin
                              r_nxt.rd_len  = ssd_pkg::LEN_NONE;
                              r_nxt.rsp_err = 1'b1;
                           end
                        endcase
                     end
                     ssd_pkg::CMD_POS_VER: begin
                        r_nxt.rd_len  = ssd_pkg::LEN_8;
                        r_nxt.rsp_err = 1'b0;
                        case (CMD_DNO)
                           ssd_pkg::DNO_POS_PULSE: r_nxt.rd_data = {32'h0, ABS_POS_PULSE};
                           ssd_pkg::DNO_POS_CMD:   r_nxt.rd_data = {32'h0, ABS_POS_CMD};
                           ssd_pkg::DNO_VERSION: begin
                              r_nxt.rd_data = FW_VERSION;
                              r_nxt.rd_len  = ssd_pkg::LEN_16;
                           end
                           default: begin
                              r_nxt.rd_len  = ssd_pkg::LEN_NONE;
                              r_nxt.rsp_err = 1'b1;
                           end
                        endcase
                     end
                     default: r_nxt.rsp_err = 1'b1;
                  endcase
               end else begin
                  case (CMD_CODE)
                     ssd_pkg::CMD_STAT_CLR: begin
                        if (CMD_DNO == ssd_pkg::DNO_00 && key_ok(CMD_DATA)) begin
                           r_nxt.stat_clr = 1'b1;
                           r_nxt.rsp_err  = 1'b0;
                        end
                     end
                     ssd_pkg::CMD_GROUP_SEL: begin
                        if (CMD_DNO == ssd_pkg::DNO_00 && group_ok(CMD_DATA)) begin
                           r_nxt.group   = CMD_DATA[3:0];
                           r_nxt.rsp_err = 1'b0;
                        end
                     end
                     ssd_pkg::CMD_PARAM_WR: begin
                        // Lands in whatever group was last selected; the host orders that
                        if (CMD_DNO != ssd_pkg::DNO_00) begin
                           r_nxt.param_wr = 1'b1;
                           r_nxt.index    = CMD_DNO;
                           r_nxt.value    = CMD_DATA;
                           r_nxt.rsp_err  = 1'b0;
                        end
                     end
                     ssd_pkg::CMD_EXT_IN: begin
                        if (CMD_DNO >= ssd_pkg::DNO_EXT_FIRST &&
                            CMD_DNO <= ssd_pkg::DNO_EXT_LAST) begin
                           r_nxt.ext_in[ext_sel*32 +: 32] = CMD_DATA[31:0];
                           r_nxt.ext_wr  = 1'b1;
                           r_nxt.rsp_err = 1'b0;
                        end
                     end
                     ssd_pkg::CMD_ALARM: begin
                        if (key_ok(CMD_DATA)) begin
                           if (CMD_DNO == ssd_pkg::DNO_HIST_CLR) begin
                              r_nxt.hist_clr = 1'b1;
                              r_nxt.rsp_err  = 1'b0;
                           end else if (CMD_DNO == ssd_pkg::DNO_00) begin
                              r_nxt.alm_clr = 1'b1;
                              r_nxt.rsp_err = 1'b0;
                           end
                        end
                     end
                     ssd_pkg::CMD_PROHIBIT: begin
                        if (key_ok(CMD_DATA)) begin
                           r_nxt.rsp_err = 1'b0;
                           case (CMD_DNO)
                              ssd_pkg::DNO_IN_OFF:  r_nxt.in_proh  = 1'b1;
                              ssd_pkg::DNO_OUT_OFF: r_nxt.out_proh = 1'b1;
                              ssd_pkg::DNO_IN_ON:   r_nxt.in_proh  = 1'b0;
                              ssd_pkg::DNO_OUT_ON:  r_nxt.out_proh = 1'b0;
                              default:              r_nxt.rsp_err  = 1'b1;
                           endcase
                        end
                     end
                     default: r_nxt.rsp_err = 1'b1;
                  endcase
               end
            end
         end
         ST_RESP: r_nxt.st = ST_IDLE;
         default: r_nxt.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         r_r       <= '0;
         r_r.st    <= ST_IDLE;
         r_r.group <= ssd_pkg::GROUP_RESET;
      end else begin
         r_r <= r_nxt;
      end
   end

   ssd_io_gate u_gate (
      .clk      (CLK_SYS),
      .nrst     (NRST),
      .in_proh  (r_r.in_proh),
      .out_proh (r_r.out_proh),
      .din_raw  (DIN_RAW),
      .dout_req (DOUT_REQ),
      .din_eff  (DIN_EFF),
      .dout_eff (DOUT_EFF)
   );

   assign CMD_READY      = (r_r.st == ST_IDLE);
   assign RSP_VALID      = r_r.rsp_valid;
   assign RSP_ERR        = r_r.rsp_err;
   assign RSP_DATA       = r_r.rd_data;
   assign RSP_LEN        = r_r.rd_len;
   assign PARAM_WR       = r_r.param_wr;
   assign PARAM_GROUP    = r_r.group;
   assign PARAM_INDEX    = r_r.index;
   assign PARAM_VALUE    = r_r.value;
   assign EXT_IN_WR      = r_r.ext_wr;
   assign EXT_IN_DATA    = r_r.ext_in;
   assign STATUS_CLR     = r_r.stat_clr;
   assign ALARM_CLR      = r_r.alm_clr;
   assign ALARM_HIST_CLR = r_r.hist_clr;
   assign IN_PROHIBIT    = r_r.in_proh;
   assign OUT_PROHIBIT   = r_r.out_proh;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);

   a_dreg_read_value: assert property (
      (take && !CMD_WRITE && CMD_CODE == 8'h6e && CMD_DNO == 8'h02 && PROGRAM_CONTROL)
      |=> RSP_VALID && !RSP_ERR && RSP_LEN == 5'h08 &&
          RSP_DATA[31:0] == $past(DATA_GENERAL_REGISTER[63:32]))
      else $error("data register read returned wrong value");

   a_reg_count_read: assert property (
      (take && !CMD_WRITE && CMD_CODE == 8'h6f && CMD_DNO == 8'h01 && PROGRAM_CONTROL)
      |=> !RSP_ERR && RSP_DATA[31:0] == $past(DATA_REG_COUNT))
      else $error("register count read wrong");

   a_mode_code_read: assert property (
      (take && !CMD_WRITE && CMD_CODE == 8'h00 && CMD_DNO == 8'h1e)
      |=> RSP_LEN == 5'h04 && RSP_DATA[15:0] == ($past(PROGRAM_CONTROL) ? 16'h0007 : 16'h0006))
      else $error("control mode code wrong");

   a_version_len: assert property (
      (take && !CMD_WRITE && CMD_CODE == 8'h02 && CMD_DNO == 8'h70)
      |=> RSP_LEN == 5'h10 && RSP_DATA == FW_VERSION)
      else $error("version read wrong");

   a_hist_clr_cause: assert property (
      ALARM_HIST_CLR |-> $past(take && CMD_WRITE && CMD_CODE == 8'h82 &&
                               CMD_DNO == 8'h20 && CMD_DATA[15:0] == 16'h1ea5))
      else $error("alarm history cleared without keyed command");

   a_group_select: assert property (
      (take && CMD_WRITE && CMD_CODE == 8'h85 && CMD_DNO == 8'h00 && CMD_DATA == 48'hc)
      |=> PARAM_GROUP == 4'hc ##1 PARAM_GROUP == 4'hc)
      else $error("group select not stored");

   a_param_write: assert property (
      (take && CMD_WRITE && CMD_CODE == 8'h94 && CMD_DNO != 8'h00)
      |=> PARAM_WR && PARAM_INDEX == $past(CMD_DNO) && PARAM_VALUE == $past(CMD_DATA)
          ##1 !PARAM_WR)
      else $error("parameter write not issued");

   a_in_prohibit: assert property (
      (take && CMD_WRITE && CMD_CODE == 8'h90 && CMD_DNO == 8'h00 && CMD_DATA[15:0] == 16'h1ea5)
      |=> IN_PROHIBIT ##1 (DIN_EFF & 16'hfff8) == 16'h0000)
      else $error("input prohibition not applied");

   a_out_release: assert property (
      (take && CMD_WRITE && CMD_CODE == 8'h90 && CMD_DNO == 8'h13 && CMD_DATA[15:0] == 16'h1ea5)
      |=> !OUT_PROHIBIT ##1 DOUT_EFF == $past(DOUT_REQ))
      else $error("output prohibition not lifted");

   a_wrong_key_kept: assert property (
      (take && CMD_WRITE && CMD_CODE == 8'h90 && CMD_DATA[15:0] != 16'h1ea5)
      |=> RSP_ERR && $stable(IN_PROHIBIT) && $stable(OUT_PROHIBIT))
      else $error("wrong key changed state");

   a_mode_reject: assert property (
      (take && !CMD_WRITE && CMD_CODE == 8'h6e && !PROGRAM_CONTROL)
      |=> RSP_VALID && RSP_ERR && RSP_LEN == 5'h00)
      else $error("point table mode read not rejected");
endmodule
`default_nettype wire

/* ssd_host_model.sv */
// Host controller model: issues one command at a time on the command port.
// Assumes the decoder answers within a few cycles of taking a request.
`default_nettype none
module ssd_host_model (
   input  wire logic        clk,
   input  wire logic        cmd_ready,
   input  wire logic        rsp_valid,
   output logic             cmd_valid,
   output logic             cmd_write,
   output logic      [7:0]  cmd_code,
   output logic      [7:0]  cmd_dno,
   output logic      [47:0] cmd_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cmd_valid = 1'b0;
      {cmd_write, cmd_code, cmd_dno, cmd_data} = '0;
   end
   task automatic send(input logic w, input logic [7:0] c, d, input logic [47:0] v,
                       output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      {cmd_write, cmd_code, cmd_dno, cmd_data} = {w, c, d, v};
      while (cmd_ready !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      // Idle fields are inverted so a stale request can never look current
      cmd_valid = 1'b0;
      {cmd_write, cmd_code, cmd_dno, cmd_data} = ~{w, c, d, v};
      n = 0;
      while (rsp_valid !== 1'b1 && n < 3) begin
         @(posedge clk);
         #1;
         n++;
      end
      ok = (rsp_valid === 1'b1);
   endtask
endmodule
`default_nettype wire

/* servo_serial_command_decoder_tb.sv */
// Self-checking bench: reference model of the decoder compared at every answer.
// Assumes the host model drives the command port one request at a time.
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module servo_serial_command_decoder_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // Arbitrary value, stands in for a version string
   localparam logic [63:0] FWV = 64'h0000_0000_0000_00a5;
   logic clk = 1'b0, nrst = 1'b0, prog = 1'b0;
   logic [127:0] dreg = '0;
   logic [31:0] icnt = '0, dcnt = '0, pp = '0, pc = '0;
   logic [15:0] tmc = '0, stc = '0, dinr = '0, doutr = '0, dine, doute;
   logic cv, cw, ready, rv, rerr, pwr, ewr, sclr, aclr, hclr, iph, oph;
   logic [7:0] cc, cd, pidx;
   logic [47:0] cdat, pval;
   logic [63:0] rdata;
   logic [4:0] rlen;
   logic [3:0] pgrp;
   logic [95:0] edat;
   int n_errors = 0, comparisons = 0, cyc = 0, seed = 83;
   logic [3:0] m_grp = '0;
   logic m_ip = 1'b0, m_op = 1'b0;
   logic [95:0] m_ext = '0;
   logic [7:0] m_idx = '0;
   logic [47:0] m_val = '0;
   // Last entry of each list is a code the decoder does not know at all
   logic [15:0] rdl [18] = '{16'h6e01, 16'h6e02, 16'h6e03, 16'h6e04, 16'h6e05, 16'h6e00,
      16'h6f00, 16'h6f01, 16'h6f02, 16'h0012, 16'h001d, 16'h001e, 16'h0013, 16'h0290,
      16'h0291, 16'h0270, 16'h0271, 16'h6c00};
   logic [15:0] wrl [11] = '{16'h8100, 16'h8101, 16'h8220, 16'h8200, 16'h8221, 16'h9000,
      16'h9003, 16'h9010, 16'h9013, 16'h9001, 16'h8b00};

   always #5 clk = ~clk;

   ssd_host_model host (.clk(clk), .cmd_ready(ready), .rsp_valid(rv), .cmd_valid(cv),
      .cmd_write(cw), .cmd_code(cc), .cmd_dno(cd), .cmd_data(cdat));

   ssd_decoder #(.FW_VERSION(FWV)) DUT (.CLK_SYS(clk), .NRST(nrst), .CMD_VALID(cv),
      .CMD_READY(ready), .CMD_WRITE(cw), .CMD_CODE(cc), .CMD_DNO(cd), .CMD_DATA(cdat),
      .PROGRAM_CONTROL(prog), .DATA_GENERAL_REGISTER(dreg), .INT_REG_COUNT(icnt),
      .DATA_REG_COUNT(dcnt), .TEST_MODE_CODE(tmc), .STORE_TYPE_CODE(stc),
      .ABS_POS_PULSE(pp), .ABS_POS_CMD(pc), .DIN_RAW(dinr), .DOUT_REQ(doutr),
      .RSP_VALID(rv), .RSP_ERR(rerr), .RSP_DATA(rdata), .RSP_LEN(rlen), .PARAM_WR(pwr),
      .PARAM_GROUP(pgrp), .PARAM_INDEX(pidx), .PARAM_VALUE(pval), .EXT_IN_WR(ewr),
      .EXT_IN_DATA(edat), .STATUS_CLR(sclr), .ALARM_CLR(aclr), .ALARM_HIST_CLR(hclr),
      .IN_PROHIBIT(iph), .OUT_PROHIBIT(oph), .DIN_EFF(dine), .DOUT_EFF(doute));

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Pulse order in p: ext, param, history, alarm, status
   task automatic run(input logic w, input logic [7:0] c, d, input logic [47:0] v);
      logic ok, e, k;
      logic [63:0] rd;
      logic [4:0] ln, p;
      e = 1'b1; rd = '0; ln = '0; p = '0;
      k = (v[15:0] == 16'h1ea5);
      dinr = 16'($random(seed));
      doutr = 16'($random(seed));
      if (!w) begin
         e = 1'b0;
         if (c == 8'h6e && prog && d >= 8'h01 && d <= 8'h04)
            {ln, rd} = {5'h08, 32'h0, dreg[(int'(d) - 1) * 32 +: 32]};
         else if (c == 8'h6f && prog && d <= 8'h01) {ln, rd} = {5'h08, 32'h0, d[0] ? dcnt : icnt};
         else if (c == 8'h00 && d == 8'h12) {ln, rd} = {5'h04, 48'h0, tmc};
         else if (c == 8'h00 && d == 8'h1d) {ln, rd} = {5'h04, 48'h0, stc};
         else if (c == 8'h00 && d == 8'h1e) {ln, rd} = {5'h04, 60'h0, prog ? 4'h7 : 4'h6};
         else if (c == 8'h02 && d[7:1] == 7'h48) {ln, rd} = {5'h08, 32'h0, d[0] ? pc : pp};
         else if (c == 8'h02 && d == 8'h70) {ln, rd} = {5'h10, FWV};
         else e = 1'b1;
      end else begin
         case (c)
            8'h81: if (d == 8'h00 && k) {e, p[0]} = 2'b01;
            8'h82: if (k && (d == 8'h00 || d == 8'h20)) {e, p[2:1]} = {1'b0, d[5], !d[5]};
            8'h90: if (k && d inside {8'h00, 8'h03, 8'h10, 8'h13}) begin
               e = 1'b0;
               if (d[1]) m_op = !d[4];
               else m_ip = !d[4];
            end
            8'h85: if (d == 8'h00 && (v <= 48'h5 || v == 48'hc)) {e, m_grp} = {1'b0, v[3:0]};
            8'h94: if (d != 8'h00) {e, p[3], m_idx, m_val} = {2'b01, d, v};
            8'h92: if (d >= 8'h60 && d <= 8'h62) begin
               {e, p[4]} = 2'b01;
               m_ext[(int'(d) - 96) * 32 +: 32] = v[31:0];
            end
            default: ;
         endcase
      end
      host.send(w, c, d, v, ok);
      `CHK("rsp_valid", 1'b1, ok)
      `CHK("cmd_ready_busy", 1'b0, ready)
      `CHK("rsp_err", e, rerr)
      `CHK("rsp_len", ln, rlen)
      `CHK("rsp_data", rd, rdata)
      `CHK("pulses", p, {ewr, pwr, hclr, aclr, sclr})
      `CHK("group", m_grp, pgrp)
      `CHK("param", {m_idx, m_val}, {pidx, pval})
      `CHK("ext_in", m_ext, edat)
      repeat (2) @(posedge clk);
      #1;
      `CHK("prohibit", {m_ip, m_op}, {iph, oph})
      `CHK("cmd_ready_idle", 1'b1, ready)
      `CHK("din_eff", m_ip ? dinr & 16'h0007 : dinr, dine)
      `CHK("dout_eff", m_op ? 16'h0000 : doutr, doute)
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         final_report();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      for (int pm = 0; pm < 2; pm++) begin
         prog = pm[0];
         dreg = {$random(seed), $random(seed), $random(seed), $random(seed)};
         {icnt, dcnt, pp, pc} = {$random(seed), $random(seed), $random(seed), $random(seed)};
         {tmc, stc} = {16'(pm), 16'(pm + 1)};
         foreach (rdl[i]) run(1'b0, rdl[i][15:8], rdl[i][7:0], '0);
      end
      $display("test reads done");
      foreach (wrl[i]) begin
         run(1'b1, wrl[i][15:8], wrl[i][7:0], 48'h1ea5);
         run(1'b1, wrl[i][15:8], wrl[i][7:0], {32'h0, 16'h1ea5 ^ (16'($random(seed)) | 16'h1)});
      end
      $display("test keyed writes done");
      for (int g = 0; g < 14; g++) begin
         run(1'b1, 8'h85, 8'h00, 48'(g));
         run(1'b1, 8'h94, 8'($random(seed)), 48'({$random(seed), $random(seed)}));
      end
      run(1'b1, 8'h94, 8'h00, 48'h1234);
      $display("test parameters done");
      // Set a prohibition first so the reset has a level to clear
      run(1'b1, 8'h90, 8'h00, 48'h1ea5);
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("reset_state", {1'b1, 4'h0, 2'b00}, {ready, pgrp, iph, oph})
      nrst = 1'b1;
      {m_grp, m_ip, m_op, m_idx, m_val, m_ext} = '0;
      $display("test mid-run reset done");
      for (int d = 'h5f; d < 'h64; d++) run(1'b1, 8'h92, 8'(d), 48'($random(seed)));
      $display("test external inputs done");
      final_report();
   end
endmodule
`default_nettype wire
